// ### emac_top.sv
// Register bank for the accumulator 1 and 2 control fields, with field decode and sign shaping.
// Assumes one clock and a register port whose read data appears the cycle after the read strobe.
//
// Local design decision: strobed register access.
module emac_top #(
  parameter int SAMPLE_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [emac_pkg::ADDR_W-1:0] addr_i,
  input wire logic [emac_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [emac_pkg::DATA_W-1:0] rdata_o,
  output emac_pkg::emac_acc_cfg_t acc1_cfg_o,
  output emac_pkg::emac_acc_cfg_t acc2_cfg_o,
  input wire logic signed [SAMPLE_W-1:0] acc1_sample_i,
  input wire logic signed [SAMPLE_W-1:0] acc2_sample_i,
  output logic signed [SAMPLE_W-1:0] acc1_add_o,
  output logic signed [SAMPLE_W-1:0] acc2_add_o
);

  // Index 0 serves accumulator 1 and index 1 accumulator 2 in all per-accumulator logic.
  localparam int NUM_ACC = 2;

  logic [emac_pkg::DATA_W-1:0] held_word;
  logic [emac_pkg::DATA_W-1:0] rdata_r;
  logic [emac_pkg::DATA_W-1:0] rdata_nxt;
  logic addr_hit;
  logic wr_hit;
  logic rd_hit;
  emac_pkg::emac_acc_cfg_t [NUM_ACC-1:0] cfg_q;
  logic [NUM_ACC-1:0][SAMPLE_W-1:0] add_q;

  // Only one word is mapped; a miss drops the write and reads back zero.
  always_comb
  begin
    addr_hit = 1'b0;
    if (addr_i == emac_pkg::CTRL_TWO_OFF)
    begin
      addr_hit = 1'b1;
    end
    else
    begin
      addr_hit = 1'b0;
    end
  end

  // Strobes qualify the decode here so that both paths share one compare.
  assign wr_hit = wr_i && addr_hit;
  assign rd_hit = rd_i && addr_hit;

  // Bits owned by other accumulators are not stored, which saves flops and keeps them reading as zero.
  for (genvar b = 0; b < emac_pkg::DATA_W; b++)
  begin : g_bit
    if (emac_pkg::CTRL_TWO_MASK[b] == 1'b0)
    begin : g_unheld
      assign held_word[b] = 1'b0;
    end
  end

  // Read data stands for one cycle only and is zero otherwise, so a stale word never lingers on the port.
  always_comb
  begin
    rdata_nxt = '0;
    if (rd_hit)
    begin
      rdata_nxt = held_word;
    end
    else if (rd_i)
    begin
      // Reads of unmapped addresses answer zero.
      rdata_nxt = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_r <= '0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // Both accumulators share one decode; only the field positions and the channel bits differ.
  for (genvar i = 0; i < NUM_ACC; i++)
  begin : g_acc
    localparam int MODE_LSB = (i == 0) ? emac_pkg::ACC1_MODE_LSB : emac_pkg::ACC2_MODE_LSB;
    localparam int TYPE_LSB = (i == 0) ? emac_pkg::ACC1_TYPE_LSB : emac_pkg::ACC2_TYPE_LSB;
    localparam int SIGN_LSB = (i == 0) ? emac_pkg::ACC1_SIGN_LSB : emac_pkg::ACC2_SIGN_LSB;
    // Accumulator 2 channel enables sit in bits not held here, so they stay disabled.
    localparam bit HAS_CHAN = (i == 0);

    logic [emac_pkg::FIELD_W-1:0] mode_r;
    logic [emac_pkg::FIELD_W-1:0] mode_nxt;
    logic [emac_pkg::FIELD_W-1:0] type_r;
    logic [emac_pkg::FIELD_W-1:0] type_nxt;
    logic [emac_pkg::FIELD_W-1:0] sign_r;
    logic [emac_pkg::FIELD_W-1:0] sign_nxt;
    logic cha_r;
    logic cha_nxt;
    logic chb_r;
    logic chb_nxt;

    logic signed [SAMPLE_W-1:0] sample;
    logic sample_neg;
    logic signed [SAMPLE_W-1:0] sample_flip;
    emac_pkg::emac_acc_cfg_t cfg_r;
    emac_pkg::emac_acc_cfg_t cfg_nxt;
    logic signed [SAMPLE_W-1:0] add_r;
    logic signed [SAMPLE_W-1:0] add_nxt;

    // Each field keeps its value until a write to the control word replaces it.
    always_comb
    begin
      mode_nxt = mode_r;
      type_nxt = type_r;
      sign_nxt = sign_r;
      cha_nxt = cha_r;
      chb_nxt = chb_r;
      if (wr_hit)
      begin
        mode_nxt = wdata_i[MODE_LSB +: emac_pkg::FIELD_W];
        type_nxt = wdata_i[TYPE_LSB +: emac_pkg::FIELD_W];
        sign_nxt = wdata_i[SIGN_LSB +: emac_pkg::FIELD_W];
        if (HAS_CHAN)
        begin
          cha_nxt = wdata_i[emac_pkg::ACC1_CHA_BIT];
          chb_nxt = wdata_i[emac_pkg::ACC1_CHB_BIT];
        end
      end
    end

    // Fields reset to their defaults, which select power mode, active type and positive values.
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        mode_r <= emac_pkg::CTRL_TWO_RST[MODE_LSB +: emac_pkg::FIELD_W];
        type_r <= emac_pkg::CTRL_TWO_RST[TYPE_LSB +: emac_pkg::FIELD_W];
        sign_r <= emac_pkg::CTRL_TWO_RST[SIGN_LSB +: emac_pkg::FIELD_W];
        cha_r <= emac_pkg::CTRL_TWO_RST[emac_pkg::ACC1_CHA_BIT];
        chb_r <= emac_pkg::CTRL_TWO_RST[emac_pkg::ACC1_CHB_BIT];
      end
      else
      begin
        mode_r <= mode_nxt;
        type_r <= type_nxt;
        sign_r <= sign_nxt;
        cha_r <= cha_nxt;
        chb_r <= chb_nxt;
      end
    end

    // The held fields rebuild the word for read-back.
    assign held_word[MODE_LSB +: emac_pkg::FIELD_W] = mode_r;
    assign held_word[TYPE_LSB +: emac_pkg::FIELD_W] = type_r;
    assign held_word[SIGN_LSB +: emac_pkg::FIELD_W] = sign_r;
    if (HAS_CHAN)
    begin : g_chan
      assign held_word[emac_pkg::ACC1_CHA_BIT] = cha_r;
      assign held_word[emac_pkg::ACC1_CHB_BIT] = chb_r;
    end

    if (i == 0)
    begin : g_sample_one
      assign sample = acc1_sample_i;
    end
    else
    begin : g_sample_two
      assign sample = acc2_sample_i;
    end

    // The most negative sample has no positive twin, so its negation wraps to itself.
    assign sample_neg = sample[SAMPLE_W-1];
    assign sample_flip = -sample;

    // Decoding the next field values keeps the settings registered yet current in the cycle after a write.
    always_comb
    begin
      cfg_nxt = '0;
      cfg_nxt.src = emac_pkg::emac_src_t'(mode_nxt);
      cfg_nxt.chan_a_en = cha_nxt;
      cfg_nxt.chan_b_en = chb_nxt;
      cfg_nxt.sign = emac_pkg::emac_sign_t'(sign_nxt);
      // Type flags follow the mode, so constant and fundamental modes show none.
      case (cfg_nxt.src)
        emac_pkg::EMAC_SRC_POWER:
        begin
          case (type_nxt)
            emac_pkg::TYPE_REACTIVE:
            begin
              cfg_nxt.pwr_reactive = 1'b1;
            end
            emac_pkg::TYPE_APPARENT:
            begin
              cfg_nxt.pwr_apparent = 1'b1;
            end
            emac_pkg::TYPE_ACTIVE_LO, emac_pkg::TYPE_ACTIVE_HI:
            begin
              cfg_nxt.pwr_active = 1'b1;
            end
            default:
            begin
              cfg_nxt.pwr_active = 1'b0;
            end
          endcase
        end
        emac_pkg::EMAC_SRC_RMS:
        begin
          // Only the upper type bit matters in current RMS mode.
          cfg_nxt.rms_sum = ~type_nxt[emac_pkg::TYPE_DIFF_BIT];
          cfg_nxt.rms_diff = type_nxt[emac_pkg::TYPE_DIFF_BIT];
        end
        emac_pkg::EMAC_SRC_CONST:
        begin
          cfg_nxt.rms_sum = 1'b0;
        end
        emac_pkg::EMAC_SRC_FUND:
        begin
          cfg_nxt.rms_diff = 1'b0;
        end
        default:
        begin
          cfg_nxt.rms_sum = 1'b0;
        end
      endcase
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        cfg_r <= emac_pkg::ACC_CFG_RST;
      end
      else
      begin
        cfg_r <= cfg_nxt;
      end
    end

    // Shaping uses the sign setting already in force, so a new setting applies from the next sample.
    always_comb
    begin
      add_nxt = '0;
      case (cfg_r.sign)
        emac_pkg::EMAC_SIGN_POS:
        begin
          if (!sample_neg)
          begin
            add_nxt = sample;
          end
        end
        emac_pkg::EMAC_SIGN_NEG:
        begin
          if (sample_neg)
          begin
            add_nxt = sample_flip;
          end
        end
        emac_pkg::EMAC_SIGN_RAW:
        begin
          add_nxt = sample;
        end
        default:
        begin
          if (sample_neg)
          begin
            add_nxt = sample_flip;
          end
          else
          begin
            add_nxt = sample;
          end
        end
      endcase
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        add_r <= '0;
      end
      else
      begin
        add_r <= add_nxt;
      end
    end

    assign cfg_q[i] = cfg_r;
    assign add_q[i] = add_r;
  end

  // Every output comes straight from a flip-flop.
  assign rdata_o = rdata_r;
  assign acc1_cfg_o = cfg_q[0];
  assign acc2_cfg_o = cfg_q[1];
  assign acc1_add_o = add_q[0];
  assign acc2_add_o = add_q[1];
endmodule

// ### emac_pkg.sv
// Package for the energy accumulator mode configuration block.
// Assumes a simple register port and an accumulator datapath that consumes the decoded fields.
// Contract
// - Control word at offset 0x04, read/write.
// - Accumulator 1 mode bits 7:6 select source.
// - Bit 5 gates channel A into accumulator 1.
// - Bit 4 gates channel B into accumulator 1.
// - Bits 3:2 give accumulator 1 type.
// - Bits 11:10 give accumulator 2 type.
// - Sign processing: positive, negative, raw, absolute.
// - Negative-only mode adds negated negative values.
// - Accumulator 2 mode bits 15:14 select source.
package emac_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_TWO_OFF = 8'h04;
  localparam logic [DATA_W-1:0] CTRL_TWO_RST = 32'h0000_0000;
  // Bits 31:16 and 13:12 belong to other accumulators and are not held here.
  localparam logic [DATA_W-1:0] CTRL_TWO_MASK = 32'h0000_CFFF;
  localparam int ACC1_MODE_LSB = 6;
  localparam int ACC1_CHA_BIT = 5;
  localparam int ACC1_CHB_BIT = 4;
  localparam int ACC1_TYPE_LSB = 2;
  localparam int ACC1_SIGN_LSB = 0;
  localparam int ACC2_MODE_LSB = 14;
  localparam int ACC2_TYPE_LSB = 10;
  localparam int ACC2_SIGN_LSB = 8;
  localparam int FIELD_W = 2;
  localparam int TYPE_DIFF_BIT = 1;
  localparam logic [1:0] TYPE_ACTIVE_LO = 2'h0;
  localparam logic [1:0] TYPE_REACTIVE = 2'h1;
  localparam logic [1:0] TYPE_APPARENT = 2'h2;
  localparam logic [1:0] TYPE_ACTIVE_HI = 2'h3;

  typedef enum logic [1:0] {
    EMAC_SRC_POWER = 2'b00,
    EMAC_SRC_RMS = 2'b01,
    EMAC_SRC_CONST = 2'b10,
    EMAC_SRC_FUND = 2'b11
  } emac_src_t;

  typedef enum logic [1:0] {
    EMAC_SIGN_POS = 2'b00,
    EMAC_SIGN_NEG = 2'b01,
    EMAC_SIGN_RAW = 2'b10,
    EMAC_SIGN_ABS = 2'b11
  } emac_sign_t;

  // Decoded settings for one accumulator.
  typedef struct packed {
    emac_src_t src;
    logic chan_a_en;
    logic chan_b_en;
    logic pwr_active;
    logic pwr_reactive;
    logic pwr_apparent;
    logic rms_sum;
    logic rms_diff;
    emac_sign_t sign;
  } emac_acc_cfg_t;

  // Settings shown while the control word holds its reset value: power mode, active type, positive only.
  localparam emac_acc_cfg_t ACC_CFG_RST = '{src: EMAC_SRC_POWER, chan_a_en: 1'b0, chan_b_en: 1'b0,
                                           pwr_active: 1'b1, pwr_reactive: 1'b0, pwr_apparent: 1'b0,
                                           rms_sum: 1'b0, rms_diff: 1'b0, sign: EMAC_SIGN_POS};
endpackage

// ### emac_props.sv
// Checker for emac_top: register port, field decode and sign shaping.
// Assumes it is bound into emac_top and sees only its ports.
module emac_props #(parameter int SAMPLE_W = 32) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire emac_pkg::emac_acc_cfg_t acc1_cfg_o,
  input wire emac_pkg::emac_acc_cfg_t acc2_cfg_o,
  input wire logic signed [SAMPLE_W-1:0] acc1_sample_i,
  input wire logic signed [SAMPLE_W-1:0] acc1_add_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_s; wr_i && addr_i == 8'h04; endsequence
  sequence rd_s; rd_i && addr_i == 8'h04; endsequence
  src_mode_a:
    assert property (wr_s |=> {acc2_cfg_o.src, acc1_cfg_o.src} == $past({wdata_i[15:14], wdata_i[7:6]}))
    else $error("bad mode");
  chan_gate_a:
    assert property (wr_s |=> {acc1_cfg_o.chan_a_en, acc1_cfg_o.chan_b_en} == $past(wdata_i[5:4]))
    else $error("bad gate");
  sign_sel_a:
    assert property (wr_s |=> {acc2_cfg_o.sign, acc1_cfg_o.sign} == $past({wdata_i[9:8], wdata_i[1:0]}))
    else $error("bad sign");
  type_one_a:
    assert property (wr_s |=> acc1_cfg_o.pwr_apparent == ($past(wdata_i[7:6]) == 2'h0 && $past(wdata_i[3:2]) == 2'h2)
    && acc1_cfg_o.rms_diff == ($past(wdata_i[7:6]) == 2'h1 && $past(wdata_i[3]))) else $error("bad type1");
  type_two_a:
    assert property (wr_s |=> acc2_cfg_o.pwr_reactive == ($past({wdata_i[15:14], wdata_i[11:10]}) == 4'h1))
    else $error("bad type2");
  read_back_a:
    assert property (wr_s ##1 rd_s |=> rdata_o == ($past(wdata_i, 2) & 32'h0000_CFFF))
    else $error("bad readback");
  read_once_a:
    assert property (rd_s ##1 !rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data held too long");
  unmapped_read_a:
    assert property (rd_i && addr_i != 8'h04 |=> rdata_o == 0) else $error("bad unmapped");
  neg_only_a:
    assert property (acc1_cfg_o.sign == emac_pkg::EMAC_SIGN_NEG |=>
    acc1_add_o == ($past(acc1_sample_i) < 0 ? -$past(acc1_sample_i) : 0)) else $error("bad negate");
endmodule
bind emac_top emac_props #(.SAMPLE_W(SAMPLE_W)) u_props (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .acc1_cfg_o(acc1_cfg_o),
  .acc2_cfg_o(acc2_cfg_o), .acc1_sample_i(acc1_sample_i), .acc1_add_o(acc1_add_o));

// ### emac_tb.sv
// Self-checking bench for emac_top.
// Assumes the checker is bound in; the two sample inputs share one stimulus.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
  logic [7:0] addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, d;
  logic signed [31:0] s_i = 0, a1, a2, v, e;
  emac_pkg::emac_acc_cfg_t c1, c2;
  logic [1:0] m, t;
  logic [4:0] f;
  int bad_count = 0, n_checks = 0, cyc = 0;
  emac_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .acc1_cfg_o(c1), .acc2_cfg_o(c2), .acc1_sample_i(s_i), .acc2_sample_i(s_i),
    .acc1_add_o(a1), .acc2_add_o(a2));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc == 5000) finish_test(1);
  task finish_test(input int to);
    bad_count += to;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) $display("Error %0t: got %h want %h", $time, g, x);
    if (g !== x) bad_count++;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= w;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1 d = rdata_o;
  endtask
  task t_rw;
    rd(8'h04);
    chk(d, 0);
    wr(8'h04, 32'hFFFF_FFFF);
    wr(8'h05, 0);
    rd(8'h04);
    chk(d, 32'h0000_CFFF);
    rd(8'h05);
    chk(d, 0);
    @(posedge clk_i);
    addr_i <= 8'h04;
    wdata_i <= 32'h1234_5678;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1;
    chk(rdata_o, 32'h0000_4678);
    @(posedge clk_i);
    #1;
    chk(rdata_o, 0);
    $display("t_rw done");
  endtask
  task t_dec;
    for (int i = 0; i < 16; i++)
    begin
      {m, t} = i;
      wr(8'h04, {16'h0, m, 2'h0, t, 2'h3, m, 2'h2, t, 2'h1});
      f = {m == 0 && t != 1 && t != 2, m == 0 && t == 1, m == 0 && t == 2, m == 1 && !t[1], m == 1 && t[1]};
      chk(c1, {m, 2'h2, f, 2'h1});
      chk(c2, {m, 2'h0, f, 2'h3});
    end
    $display("t_dec done");
  endtask
  task t_sign;
    for (int k = 0; k < 16; k++)
    begin
      if (k[1:0] == 0) wr(8'h04, {k[3:2], 6'h0, k[3:2]});
      v = k[1:0] == 0 ? -5 : k[1:0] == 1 ? 7 : k[1:0] == 2 ? 0 : 32'sh8000_0000;
      @(posedge clk_i);
      s_i <= v;
      @(posedge clk_i);
      #1;
      e = k[3:2] == 0 ? (v < 0 ? 0 : v) : k[3:2] == 1 ? (v < 0 ? -v : 0) : k[3:2] == 2 ? v : (v < 0 ? -v : v);
      chk(a1, e);
      chk(a2, e);
    end
    $display("t_sign done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    t_rw;
    t_dec;
    t_sign;
    finish_test(0);
  end
endmodule
